// ===== hw/serial_in_parallel_out_latch.sv
`timescale 1ns/1ns
module serial_in_parallel_out_latch
#(
    parameter int WIDTH = sipo_latch_pkg::STAGE_COUNT
) (
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    input  wire logic             serial_in,
    input  wire logic             shift_clk,
    input  wire logic             shift_clear_n,
    input  wire logic             store_clk,
    input  wire logic             store_clear_n,
    output logic      [WIDTH-1:0] parallel_out,
    output logic                  cascade_out
);
    import sipo_latch_pkg::*;

    // ********************************************************
    // pin synchronisation
    // ********************************************************
    // bit order: 0 serial, 1 shift clock, 2 shift clear, 3 store
    // clock, 4 store clear; all five see the same delay so the
    // serial bit keeps its setup against the shift clock edge
    // limitation: a pin level held under one sys_clk period may
    // never reach the first flop and is then lost altogether
    logic [4:0] pins_now;
    logic [4:0] pins_old;

    pin_sync #(
        .WIDTH (5)
    ) u_sync (
        .sys_clk      (sys_clk),
        .nrst         (nrst),
        .pin_in       ({store_clear_n, store_clk, shift_clear_n,
                        shift_clk, serial_in}),
        .pin_sync_out (pins_now),
        .pin_prev     (pins_old)
    );

    // ********************************************************
    // edge classification
    // ********************************************************
    function automatic edge_kind_type edge_of(input logic now_v,
                                              input logic old_v);
        edge_kind_type k;
        k = EDGE_NONE_S;
        if (now_v && !old_v) begin
            k = EDGE_UP_S;
        end else if (!now_v && old_v) begin
            k = EDGE_DOWN_S;
        end
        return k;
    endfunction

    // ********************************************************
    // edge decode
    // ********************************************************
    wire edge_kind_type shift_edge = edge_of(pins_now[1], pins_old[1]);
    wire edge_kind_type store_edge = edge_of(pins_now[3], pins_old[3]);
    wire                shift_clr  = !pins_now[2];
    wire                store_clr  = !pins_now[4];
    wire                shift_rise = (shift_edge == EDGE_UP_S);
    wire                store_rise = (store_edge == EDGE_UP_S);

    logic [WIDTH-1:0] shift_reg;
    logic [WIDTH-1:0] shift_next;
    logic [WIDTH-1:0] store_reg;
    logic [WIDTH-1:0] store_next;

    // ********************************************************
    // shift register
    // ********************************************************
    // clear overrides any edge; falling edges fall through
    assign shift_next = shift_clr ? SHIFT_RESET
                      : shift_rise ? {shift_reg[WIDTH-2:0],
                                      pins_old[0]}
                      : shift_reg;

    // ********************************************************
    // storage register
    // ********************************************************
    // shift_reg is the value before this cycle's shift, so tied
    // clocks leave the store one shift behind
    assign store_next = store_clr ? STORE_RESET
                      : store_rise ? shift_reg
                      : store_reg;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            shift_reg <= SHIFT_RESET;
            store_reg <= STORE_RESET;
        end else begin
            shift_reg <= shift_next;
            store_reg <= store_next;
        end
    end

    // outputs straight from flip-flops, loaded from the next
    // values so they move on the same edge as the registers;
    // costs a second copy of every store stage and of the last shift stage
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            parallel_out <= STORE_RESET;
            cascade_out  <= 1'b0;
        end else begin
            parallel_out <= store_next;
            cascade_out  <= shift_next[WIDTH-1];
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    a_shift_clear_zero: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        shift_clr |=> (shift_reg == '0) && !cascade_out)
        else $error("shift clear did not zero the stages");

    a_store_clear_zero: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        store_clr |=> (parallel_out == '0))
        else $error("store clear did not zero the outputs");

    a_shift_low_in: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (!shift_clr && shift_rise && !pins_old[0])
        |=> (shift_reg[0] == 1'b0)
            && (shift_reg[WIDTH-1:1] == $past(shift_reg[WIDTH-2:0])))
        else $error("low serial bit not shifted in");

    a_shift_high_in: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (!shift_clr && shift_rise && pins_old[0])
        |=> (shift_reg[0] == 1'b1)
            && (shift_reg[WIDTH-1:1] == $past(shift_reg[WIDTH-2:0])))
        else $error("high serial bit not shifted in");

    a_shift_hold_idle: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (!shift_clr && !shift_rise) |=> $stable(shift_reg))
        else $error("shift stages moved without a rising edge");

    a_store_capture: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (!store_clr && store_rise)
        |=> (parallel_out == $past(shift_reg)))
        else $error("store did not capture shift content");

    a_store_hold_idle: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (!store_clr && !store_rise) |=> $stable(parallel_out))
        else $error("store changed without a rising edge");

    a_cascade_last: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        1'b1 |-> (cascade_out == shift_reg[WIDTH-1]))
        else $error("cascade output differs from last stage");

    a_tied_lag: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (!store_clr && !shift_clr && store_rise && shift_rise)
        |=> (parallel_out == $past(shift_reg))
            && (shift_reg == {$past(shift_reg[WIDTH-2:0]),
                              $past(pins_old[0])}))
        else $error("tied clocks did not leave store one behind");

    // ********************************************************
    // falling edges and separate clears
    // ********************************************************
    // a falling edge is checked apart from idle so that a decode
    // fault mixing the two kinds shows up here
    a_shift_fall_hold: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (!shift_clr && (shift_edge == EDGE_DOWN_S))
        |=> $stable(shift_reg))
        else $error("falling shift clock moved the stages");

    a_store_fall_hold: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (!store_clr && (store_edge == EDGE_DOWN_S))
        |=> $stable(parallel_out))
        else $error("falling store clock changed the outputs");

    // each clear reaches only its own register
    a_shift_own_clear: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (shift_clr && !store_clr && !store_rise)
        |=> $stable(parallel_out))
        else $error("shift clear disturbed the store");

    a_store_own_clear: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (store_clr && !shift_clr && !shift_rise)
        |=> $stable(shift_reg))
        else $error("store clear disturbed the shift stages");

    // a clear held across a rising edge still wins
    a_shift_clear_wins: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (shift_clr && shift_rise) |=> (shift_reg == '0))
        else $error("rising shift clock beat the shift clear");

    a_store_clear_wins: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (store_clr && store_rise) |=> (parallel_out == '0))
        else $error("rising store clock beat the store clear");

    // ********************************************************
    // outputs against the registers behind them
    // ********************************************************
    a_cascade_step: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (!shift_clr && shift_rise)
        |=> (cascade_out == $past(shift_reg[WIDTH-2])))
        else $error("cascade output did not take the stage before");

    a_store_out_match: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        1'b1 |-> (parallel_out == store_reg))
        else $error("parallel outputs differ from the store");

endmodule

// ===== hw/sipo_latch_pkg.sv
package sipo_latch_pkg;

    // ********************************************************
    // widths and reset values
    // ********************************************************
    localparam int          STAGE_COUNT    = 8;
    localparam logic [7:0]  SHIFT_RESET    = 8'h00;
    localparam logic [7:0]  STORE_RESET    = 8'h00;
    localparam int          SYNC_STAGES    = 2;
    localparam logic [1:0]  EDGE_RISE      = 2'h1;
    localparam logic [1:0]  EDGE_FALL      = 2'h2;

    // ********************************************************
    // timing of the bench link clock
    // ********************************************************
    localparam int          SYS_CLK_NS     = 20;
    localparam int          LINK_PERIOD_NS = 160;
    localparam int          LINK_HALF_CYC  = (LINK_PERIOD_NS / 2) / SYS_CLK_NS;

    typedef enum logic [1:0] {
        EDGE_NONE_S = 2'b00,
        EDGE_UP_S   = 2'b01,
        EDGE_DOWN_S = 2'b10
    } edge_kind_type;

endpackage

// ===== hw/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync_out,
    output logic      [WIDTH-1:0] pin_prev
);
    // first stage read only by the second stage
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg     <= '0;
            pin_sync_out <= '0;
            pin_prev     <= '0;
        end else begin
            meta_reg     <= pin_in;
            pin_sync_out <= meta_reg;
            pin_prev     <= pin_sync_out;
        end
    end

endmodule

// ===== tb/sipo_host.sv
`timescale 1ns/1ns
module sipo_host (
    input  wire logic sys_clk,
    output logic      serial_in,
    output logic      shift_clk,
    output logic      shift_clear_n,
    output logic      store_clk,
    output logic      store_clear_n
);
    import sipo_latch_pkg::*;

    // ************************************************
    // strobe timing, one half link period per phase
    // ************************************************
    initial begin
        serial_in     = 1'b0;
        shift_clk     = 1'b0;
        store_clk     = 1'b0;
        shift_clear_n = 1'b1;
        store_clear_n = 1'b1;
    end

    task automatic wait_half();
        repeat (LINK_HALF_CYC) @(negedge sys_clk);
    endtask

    // link clock idles low between pulses
    task automatic pulse(input logic sh, input logic st, input logic bit_v);
        serial_in = bit_v;
        wait_half();
        shift_clk = sh;
        store_clk = st;
        wait_half();
        shift_clk = 1'b0;
        store_clk = 1'b0;
        // data flips at the fall: a late sample takes the wrong bit
        serial_in = ~bit_v;
        wait_half();
    endtask

    task automatic clear_pulse(input logic sh, input logic st);
        shift_clear_n = ~sh;
        store_clear_n = ~st;
        wait_half();
        shift_clear_n = 1'b1;
        store_clear_n = 1'b1;
        wait_half();
    endtask

    // clears stay at the given level until the next call
    task automatic clear_hold(input logic sh, input logic st);
        shift_clear_n = ~sh;
        store_clear_n = ~st;
        wait_half();
    endtask
endmodule

// ===== tb/serial_in_parallel_out_latch_tb.sv
`timescale 1ns/1ns
module serial_in_parallel_out_latch_tb;
    import sipo_latch_pkg::*;

    logic       sys_clk = 1'b0;
    logic       nrst = 1'b0;
    logic       serial_in;
    logic       shift_clk;
    logic       shift_clear_n;
    logic       store_clk;
    logic       store_clear_n;
    logic [7:0] parallel_out;
    logic       cascade_out;
    logic [7:0] model_sh;
    int         num_errors = 0;
    int         check_count = 0;
    int         cycles = 0;

    always #10 sys_clk = ~sys_clk;

    serial_in_parallel_out_latch dut (.sys_clk(sys_clk), .nrst(nrst),
        .serial_in(serial_in), .shift_clk(shift_clk),
        .shift_clear_n(shift_clear_n), .store_clk(store_clk),
        .store_clear_n(store_clear_n), .parallel_out(parallel_out),
        .cascade_out(cascade_out));

    sipo_host host (.sys_clk(sys_clk), .serial_in(serial_in),
        .shift_clk(shift_clk), .shift_clear_n(shift_clear_n),
        .store_clk(store_clk), .store_clear_n(store_clear_n));

    // ************************************************
    // checking and closing
    // ************************************************
    task automatic check_val(input string what, input logic [7:0] exp,
                             input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp,
                             input logic got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // about 520 cycles expected, generous margin
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            final_report();
        end
    end

    // ************************************************
    // scenarios
    // ************************************************
    task automatic shift_byte(input logic [7:0] d, input logic [7:0] held);
        for (int i = 7; i >= 0; i--) begin
            host.pulse(1'b1, 1'b0, d[i]);
            model_sh = {model_sh[6:0], d[i]};
            check_bit("cascade", model_sh[7], cascade_out);
            check_val("held", held, parallel_out);
        end
    endtask

    task automatic test_shift_store();
        shift_byte(8'hA5, 8'h00);
        host.pulse(1'b0, 1'b1, 1'b0);
        check_val("store", 8'hA5, parallel_out);
        shift_byte(8'h5A, 8'hA5);
        host.pulse(1'b0, 1'b1, 1'b1);
        check_val("store", 8'h5A, parallel_out);
    endtask

    task automatic test_clears();
        host.clear_pulse(1'b1, 1'b0);
        model_sh = 8'h00;
        check_bit("shclr", 1'b0, cascade_out);
        check_val("keep", 8'h5A, parallel_out);
        host.pulse(1'b0, 1'b1, 1'b1);
        check_val("store0", 8'h00, parallel_out);
        shift_byte(8'hFF, 8'h00);
        host.pulse(1'b0, 1'b1, 1'b0);
        host.clear_pulse(1'b0, 1'b1);
        check_val("stclr", 8'h00, parallel_out);
        check_bit("casc", 1'b1, cascade_out);
    endtask

    // tied clocks: store lags the shift register by one pulse
    task automatic test_tied();
        shift_byte(8'h3C, 8'h00);
        host.pulse(1'b1, 1'b1, 1'b1);
        check_val("tied", 8'h3C, parallel_out);
        check_bit("tcasc", 1'b0, cascade_out);
        host.pulse(1'b1, 1'b1, 1'b0);
        check_val("tied2", 8'h79, parallel_out);
    endtask

    // both clears held low across a tied rising edge
    task automatic test_clear_wins();
        host.clear_hold(1'b1, 1'b1);
        host.pulse(1'b1, 1'b1, 1'b1);
        host.clear_hold(1'b0, 1'b0);
        model_sh = 8'h00;
        check_val("clr_win", 8'h00, parallel_out);
        check_bit("clr_wcasc", 1'b0, cascade_out);
    endtask

    initial begin
        model_sh = 8'h00;
        repeat (20) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (4) @(negedge sys_clk);
        check_val("rst_par", 8'h00, parallel_out);
        check_bit("rst_casc", 1'b0, cascade_out);
        test_shift_store();
        test_clears();
        test_tied();
        test_clear_wins();
        final_report();
    end
endmodule
